// *** hdl/interrupt_vectoring_control.sv ***
/*
  Interrupt acceptance, vectoring, entry and return sequencing, APB regs.
  Assumes core strobes on pclk, stack memory answering one cycle after rd.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module interrupt_vectoring_control
  import irq_vec_pkg::*;
#(
  parameter int N_SRC = 8,
  parameter int PC_W = 13,
  parameter int BOOT_START = 32'h0000_1c00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire logic [N_SRC-1:0] irq_cond,
  // Fuse and lock straps
  input wire logic boot_reset_fuse,
  input wire logic app_section_lock_a,
  input wire logic boot_section_lock_b,
  // Core status
  input wire logic instr_done,
  input wire instr_op_t instr_op,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic core_sleep,
  // Core control
  output logic core_hold,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_addr,
  output logic [PC_W-1:0] reset_vector,
  // Stack memory
  output stack_req_t stack,
  input wire logic [7:0] stack_rd_byte
);

  generate
    if (N_SRC < 1 || N_SRC > 15 || PC_W < 9 || PC_W > 16) begin : g_bad
      $error("interrupt_vectoring_control: unsupported parameters");
    end
  endgenerate

  localparam logic [PC_W-1:0] BOOT_PC = PC_W'(BOOT_START);

  logic gie;
  logic vector_table_select;
  logic [N_SRC-1:0] enable;
  logic [N_SRC-1:0] level_mask;
  logic [N_SRC-1:0] flag;
  logic [N_SRC-1:0] next_flag;
  logic [15:0] sp;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  seq_state_t state;
  logic [2:0] cnt;
  logic [IDX_W-1:0] cur_idx;
  logic [PC_W-1:0] ret_pc;
  logic [PC_W-1:0] vec_base;
  logic [7:0] pop_hi;
  logic [7:0] pop_lo;
  stack_req_t next_stack;
  logic [N_SRC-1:0] pending;
  logic [N_SRC-1:0] req;
  logic any_req;
  logic [IDX_W-1:0] pick_idx;
  logic [N_SRC-1:0] take_1h;
  logic [N_SRC-1:0] sw_clr;
  logic [N_SRC-1:0] lvl_wr;
  logic pc_in_boot;
  logic lock_block;
  logic at_boundary;
  logic take;
  logic ret_start;
  logic wake_end;
  logic entry_end;
  logic jump_end;
  logic ret_end;
  logic [PC_W-1:0] push_pc;
  logic apb_fire;
  logic wr_fire;
  logic mapped;
  logic [31:0] rd_val;

  // ========================================================================
  // Strap synchroniser; straps are static after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      strap_s1 <= {boot_section_lock_b, app_section_lock_a, boot_reset_fuse};
      strap_s2 <= strap_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector <= '0;
    end else begin
      reset_vector <= strap_s2[0] ? BOOT_PC : '0;
    end
  end

  // ========================================================================
  // Request qualification
  assign pending = (flag & ~level_mask) | (irq_cond & level_mask);
  assign req = pending & enable;

  irq_priority_pick #(
    .N_SRC(N_SRC)
  ) i_irq_priority_pick (
    .req(req),
    .any(any_req),
    .idx(pick_idx)
  );

  assign pc_in_boot = (next_pc >= BOOT_PC);
  // Block handlers in a section the lock forbids from being interrupted
  assign lock_block = (strap_s2[1] && !vector_table_select && pc_in_boot)
    || (strap_s2[2] && vector_table_select && !pc_in_boot);

  // Boundary excludes disable, enable and return at their own completion
  assign at_boundary = core_sleep || (instr_done && !instr_op.cli
    && !instr_op.sei && !instr_op.ret);
  assign take = (state == ST_IDLE) && any_req && gie && !lock_block
    && at_boundary;
  assign ret_start = (state == ST_IDLE) && instr_done && instr_op.ret;

  assign wake_end = (state == ST_WAKE) && (cnt == WAKE_CYC - 3'h1);
  assign entry_end = (state == ST_ENTRY) && (cnt == ENTRY_CYC - 3'h1);
  assign jump_end = (state == ST_JUMP) && (cnt == JUMP_CYC - 3'h1);
  assign ret_end = (state == ST_RET) && (cnt == RET_CYC - 3'h1);

  // ========================================================================
  // Flags: a new condition wins over both clears
  assign sw_clr = (wr_fire && paddr == OFS_FLAG) ? pwdata[N_SRC-1:0] : '0;
  // A source turned level-type drops its flag at the same edge
  assign lvl_wr = (wr_fire && paddr == OFS_LEVEL) ? pwdata[N_SRC-1:0] : '0;

  generate
    for (genvar i = 0; i < N_SRC; i++) begin : g_flag
      assign take_1h[i] = take && (pick_idx == IDX_W'(i));
      assign next_flag[i] = (level_mask[i] || lvl_wr[i]) ? 1'b0
        : irq_cond[i] ? 1'b1
        : (take_1h[i] || sw_clr[i]) ? 1'b0
        : flag[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

  // ========================================================================
  // Global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie <= GIE_RESET;
    end else if (take) begin
      gie <= 1'b0;
    end else if (instr_done && instr_op.cli) begin
      gie <= 1'b0;
    end else if (ret_end) begin
      gie <= 1'b1;
    end else if (instr_done && instr_op.sei) begin
      gie <= 1'b1;
    end else if (wr_fire && paddr == OFS_CTRL) begin
      gie <= pwdata[CTRL_GIE_BIT];
    end
  end

  // ========================================================================
  // Entry, jump, wake and return sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      core_hold <= 1'b0;
      cur_idx <= '0;
      ret_pc <= '0;
      vec_base <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 3'h0;
          if (take) begin
            state <= core_sleep ? ST_WAKE : ST_ENTRY;
            core_hold <= 1'b1;
            cur_idx <= pick_idx;
            ret_pc <= next_pc;
            vec_base <= vector_table_select ? BOOT_PC : '0;
          end else if (ret_start) begin
            state <= ST_RET;
            core_hold <= 1'b1;
          end
        end
        ST_WAKE: begin
          cnt <= wake_end ? 3'h0 : cnt + 3'h1;
          if (wake_end) begin
            state <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          cnt <= entry_end ? 3'h0 : cnt + 3'h1;
          if (entry_end) begin
            state <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          cnt <= jump_end ? 3'h0 : cnt + 3'h1;
          if (jump_end) begin
            state <= ST_IDLE;
            core_hold <= 1'b0;
          end
        end
        ST_RET: begin
          cnt <= ret_end ? 3'h0 : cnt + 3'h1;
          if (ret_end) begin
            state <= ST_IDLE;
            core_hold <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt <= 3'h0;
          core_hold <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Program counter load toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      pc_load_addr <= '0;
    end else begin
      pc_load <= entry_end || ret_end;
      if (entry_end) begin
        pc_load_addr <= vec_base
          + PC_W'((32'(cur_idx) + 32'h1) * VEC_STRIDE);
      end else if (ret_end) begin
        pc_load_addr <= PC_W'({pop_hi, pop_lo});
      end
    end
  end

  // ========================================================================
  // Stack traffic: low byte at SP, high byte at SP-1
  assign push_pc = take ? next_pc : ret_pc;

  always_comb begin
    next_stack = '0;
    if ((take && !core_sleep) || wake_end) begin
      next_stack.wr = 1'b1;
      next_stack.addr = sp;
      next_stack.wdata = push_pc[7:0];
    end else if (state == ST_ENTRY && cnt == 3'h0) begin
      next_stack.wr = 1'b1;
      next_stack.addr = sp - 16'h0001;
      next_stack.wdata = 8'(ret_pc >> 8);
    end else if (ret_start) begin
      next_stack.rd = 1'b1;
      next_stack.addr = sp + 16'h0001;
    end else if (state == ST_RET && cnt == 3'h0) begin
      next_stack.rd = 1'b1;
      next_stack.addr = sp + SP_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack <= '0;
    end else begin
      stack <= next_stack;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_hi <= 8'h00;
      pop_lo <= 8'h00;
    end else if (state == ST_RET) begin
      if (cnt == 3'h1) begin
        pop_hi <= stack_rd_byte;
      end
      if (cnt == 3'h2) begin
        pop_lo <= stack_rd_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= SP_RESET;
    end else if (state == ST_ENTRY && cnt == 3'h1) begin
      sp <= sp - SP_STEP;
    end else if (state == ST_RET && cnt == 3'h1) begin
      sp <= sp + SP_STEP;
    end else if (wr_fire && paddr == OFS_SP) begin
      sp <= pwdata[15:0];
    end
  end

  // ========================================================================
  // APB slave: one wait state, error on unmapped address
  assign apb_fire = psel && penable && pready;
  assign wr_fire = apb_fire && pwrite && mapped;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: begin
        rd_val[CTRL_GIE_BIT] = gie;
        rd_val[CTRL_VTS_BIT] = vector_table_select;
      end
      OFS_ENABLE: rd_val[N_SRC-1:0] = enable;
      OFS_FLAG: rd_val[N_SRC-1:0] = flag;
      OFS_LEVEL: rd_val[N_SRC-1:0] = level_mask;
      OFS_SP: rd_val[15:0] = sp;
      OFS_STATUS: begin
        rd_val[STAT_STATE_LSB +: 5] = state;
        rd_val[STAT_IDX_LSB +: IDX_W] = cur_idx;
        rd_val[STAT_FUSE_BIT] = strap_s2[0];
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_table_select <= VTS_RESET;
      enable <= '0;
      level_mask <= '0;
    end else if (wr_fire) begin
      if (paddr == OFS_CTRL) begin
        vector_table_select <= pwdata[CTRL_VTS_BIT];
      end
      if (paddr == OFS_ENABLE) begin
        enable <= pwdata[N_SRC-1:0];
      end
      if (paddr == OFS_LEVEL) begin
        level_mask <= pwdata[N_SRC-1:0];
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_entry;
    (state == ST_ENTRY) [*4] ##1 (state == ST_JUMP) [*3] ##1
      (state == ST_IDLE);
  endsequence

  sequence seq_return;
    (state == ST_RET) [*4] ##1 (gie && pc_load && state == ST_IDLE);
  endsequence

  chk_take_gated: assert property (
    take |-> gie && ((enable & take_1h) != '0) && !lock_block)
    else $error("interrupt taken without enables");

  chk_lock_blocks: assert property (
    lock_block |-> !take)
    else $error("interrupt taken under boot lock");

  chk_entry_clears: assert property (
    take |=> !gie)
    else $error("global enable not cleared on entry");

  chk_entry_cycles: assert property (
    take && !core_sleep |=> seq_entry)
    else $error("entry or jump length wrong");

  chk_wake_extra: assert property (
    take && core_sleep |=> (state == ST_WAKE) [*4] ##1 seq_entry)
    else $error("wake extension wrong");

  chk_return_seq: assert property (
    ret_start |=> seq_return)
    else $error("return sequence wrong");

  chk_sp_push: assert property (
    take && !core_sleep |-> ##3 (sp == $past(sp, 3) - SP_STEP))
    else $error("stack pointer not lowered by two");

  chk_flag_vector: assert property (
    take |=> ((flag & $past(take_1h) & ~$past(irq_cond)) == '0))
    else $error("flag not cleared on vectoring");

  chk_flag_w1c: assert property (
    (sw_clr != '0) |=> ((flag & $past(sw_clr) & ~$past(irq_cond)) == '0))
    else $error("flag not cleared by write one");

  chk_flag_set: assert property (
    (irq_cond & ~level_mask) != '0 |=>
      ((flag & $past(irq_cond & ~level_mask)) == $past(irq_cond & ~level_mask)))
    else $error("flag lost its event");

  chk_level_free: assert property (
    (flag & level_mask) == '0)
    else $error("level source holds a flag");

  chk_disable_now: assert property (
    instr_done && instr_op.cli |-> !take ##1 !gie)
    else $error("interrupt after disable");

  chk_enable_next: assert property (
    instr_done && instr_op.sei && !core_sleep |-> !take)
    else $error("interrupt right after enable");

endmodule : interrupt_vectoring_control

// *** hdl/irq_vec_pkg.sv ***
/*
  Constants, types and register map for the interrupt vectoring control.
  Assumes a single 200 MHz clock and an APB master with 32-bit data.
*/
// ==========================================================================
package irq_vec_pkg;

  // ========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ========================================================================
  // Field positions
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_VTS_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IDX_LSB = 8;
  localparam int STAT_FUSE_BIT = 16;

  // ========================================================================
  // Reset values
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic GIE_RESET = 1'b0;
  localparam logic VTS_RESET = 1'b0;

  // ========================================================================
  // Sequencing counts in clock cycles, then stack step in bytes, vector stride and index width
  localparam logic [2:0] WAKE_CYC = 3'h4;
  localparam logic [2:0] ENTRY_CYC = 3'h4;
  localparam logic [2:0] JUMP_CYC = 3'h3;
  localparam logic [2:0] RET_CYC = 3'h4;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam int VEC_STRIDE = 2;
  localparam int IDX_W = 4;

  // ========================================================================
  // Types
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAKE = 5'b00010,
    ST_ENTRY = 5'b00100,
    ST_JUMP = 5'b01000,
    ST_RET = 5'b10000
  } seq_state_t;

  typedef struct packed {
    logic cli;
    logic sei;
    logic ret;
  } instr_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } stack_req_t;

endpackage : irq_vec_pkg

// *** hdl/irq_priority_pick.sv ***
/*
  Fixed-priority picker: lowest requesting index wins.
  Assumes a request vector from logic on the same clock.
*/
`timescale 1ns/1ps
module irq_priority_pick
  import irq_vec_pkg::*;
#(
  parameter int N_SRC = 8
) (
  // Requests
  input wire logic [N_SRC-1:0] req,
  // Result
  output logic any,
  output logic [IDX_W-1:0] idx
);

  // ========================================================================
  // Scan from the lowest priority upward so the lowest index is kept
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule : irq_priority_pick

// *** bench/stack_mem_model.sv ***
/*
  Stack memory model standing beside the interrupt sequencer.
  Assumes one-cycle stack requests on pclk; read data follows a read
  request by one cycle and is inverted in every cycle without a read.
*/
`timescale 1ns/1ps
module stack_mem_model
  import irq_vec_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Stack port
  input wire stack_req_t stack,
  output logic [7:0] stack_rd_byte
);
  // ==========================================================================
  // Storage
  logic [7:0] mem [0:65535];
  logic [7:0] rd_byte = 8'h5a;

  // Stale read data toggles so a capture one cycle late never looks right
  always @(posedge pclk) begin
    if (stack.wr) begin
      mem[stack.addr] <= stack.wdata;
    end
    if (stack.rd) begin
      rd_byte <= mem[stack.addr];
    end else begin
      rd_byte <= ~rd_byte;
    end
  end
  assign stack_rd_byte = rd_byte;
  // Status flags are never saved here; the handler keeps them
endmodule : stack_mem_model

// *** bench/interrupt_vectoring_control_tb_top.sv ***
/*
  Self-checking bench for the interrupt vectoring control.
  Assumes the APB timing and core boundary contract of the design.
*/
`timescale 1ns/1ps
module interrupt_vectoring_control_tb_top;
  import irq_vec_pkg::*;
  localparam int BOOT = 32'h0000_1c00;
  localparam instr_op_t OP_NONE = 3'h0;
  localparam instr_op_t OP_CLI = 3'h4;
  localparam instr_op_t OP_SEI = 3'h2;
  localparam instr_op_t OP_RET = 3'h1;
  // ==========================================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] irq_cond = 8'h00;
  logic boot_reset_fuse = 1'b0;
  logic app_section_lock_a = 1'b0;
  logic boot_section_lock_b = 1'b0;
  logic instr_done = 1'b0;
  instr_op_t instr_op = 3'h0;
  logic [12:0] next_pc = 13'h0000;
  logic core_sleep = 1'b0;
  logic core_hold;
  logic pc_load;
  logic [12:0] pc_load_addr;
  logic [12:0] reset_vector;
  stack_req_t stack;
  logic [7:0] stack_rd_byte;
  logic [31:0] rst_val [0:5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
  int n_mismatch = 0;
  int checks = 0;
  int n_loads = 0;
  int n_cyc = 0;
  int c;
  int h;
  int l;
  logic [31:0] a;
  logic [31:0] r;
  logic e;

  // ==========================================================================
  // Design and partner
  interrupt_vectoring_control #(.N_SRC(8), .PC_W(13), .BOOT_START(BOOT))
  i_interrupt_vectoring_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_cond(irq_cond),
    .boot_reset_fuse(boot_reset_fuse),
    .app_section_lock_a(app_section_lock_a),
    .boot_section_lock_b(boot_section_lock_b), .instr_done(instr_done),
    .instr_op(instr_op), .next_pc(next_pc), .core_sleep(core_sleep),
    .core_hold(core_hold), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .reset_vector(reset_vector), .stack(stack),
    .stack_rd_byte(stack_rd_byte)
  );
  stack_mem_model i_stack_mem_model (
    .pclk(pclk), .stack(stack), .stack_rd_byte(stack_rd_byte)
  );

  // ==========================================================================
  // Clock, load counter and timeout
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    n_cyc++;
    if (pc_load === 1'b1) n_loads++;
    if (n_cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_val(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  function automatic logic [31:0] vec(input logic [31:0] base, input int i);
    return base + 32'((i + 1) * VEC_STRIDE);
  endfunction : vec

  // Request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, r, e);
    chk_val($sformatf("register %h", ad), exp, r);
  endtask : rd_chk

  task automatic pulse(input logic [7:0] b);
    @(posedge pclk);
    irq_cond <= b;
    @(posedge pclk);
    irq_cond <= 8'h00;
  endtask : pulse

  // One boundary (or a sleeping cycle), then watch the sequencer
  task automatic run_op(input instr_op_t o, input logic [12:0] pc,
                        input logic slp);
    int base;
    base = n_loads;
    c = 0;
    h = 0;
    a = 32'h0;
    @(posedge pclk);
    instr_done <= ~slp;
    instr_op <= o;
    next_pc <= pc;
    core_sleep <= slp;
    for (int n = 1; n <= 16; n++) begin
      @(posedge pclk);
      instr_done <= 1'b0;
      core_sleep <= 1'b0;
      #1;
      if (pc_load === 1'b1 && c == 0) begin
        c = n;
        a = 32'(pc_load_addr);
      end
      if (c != 0 && h == 0 && core_hold === 1'b0) h = n;
    end
    l = n_loads - base;
  endtask : run_op

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), rst_val[i]);
    chk_val("reset vector", 32'h0, 32'(reset_vector));
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk_val("unmapped error", 32'h1, 32'(e));
    wr(OFS_SP, 32'h0100);
    wr(OFS_ENABLE, 32'hff);
    pulse(8'h24);
    rd_chk(OFS_FLAG, 32'h24);
    wr(OFS_FLAG, 32'h0);
    rd_chk(OFS_FLAG, 32'h24);
    wr(OFS_FLAG, 32'h20);
    rd_chk(OFS_FLAG, 32'h04);
    pulse(8'h20);
    run_op(OP_NONE, 13'h0123, 1'b0);
    chk_cnt("take with global off", 0, l);
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_CTRL, 32'h1);
    run_op(OP_NONE, 13'h0123, 1'b0);
    chk_cnt("take with sources off", 0, l);
    wr(OFS_ENABLE, 32'hff);
    run_op(OP_NONE, 13'h0123, 1'b0);
    chk_cnt("entry cycles", 5, c);
    chk_cnt("jump end", 8, h);
    chk_val("priority vector", vec(0, 2), a);
    chk_val("push low", 32'h23, 32'(i_stack_mem_model.mem[16'h0100]));
    chk_val("push high", 32'h01, 32'(i_stack_mem_model.mem[16'h00ff]));
    rd_chk(OFS_SP, 32'h00fe);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_FLAG, 32'h20);
    wr(OFS_CTRL, 32'h1);
    run_op(OP_NONE, 13'h0031, 1'b0);
    chk_val("nested vector", vec(0, 5), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    chk_cnt("return cycles", 5, c);
    chk_val("nested return", 32'h0031, a);
    run_op(OP_RET, 13'h0000, 1'b0);
    chk_val("return address", 32'h0123, a);
    rd_chk(OFS_SP, 32'h0100);
    rd_chk(OFS_CTRL, 32'h1);
    pulse(8'h02);
    run_op(OP_NONE, 13'h0200, 1'b0);
    chk_val("source one vector", vec(0, 1), a);
    pulse(8'h40);
    run_op(OP_RET, 13'h0000, 1'b0);
    chk_cnt("loads after return", 1, l);
    run_op(OP_NONE, 13'h0201, 1'b0);
    chk_val("pending vector", vec(0, 6), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    pulse(8'h08);
    run_op(OP_CLI, 13'h0202, 1'b0);
    chk_cnt("take at disable", 0, l);
    rd_chk(OFS_CTRL, 32'h0);
    run_op(OP_SEI, 13'h0203, 1'b0);
    chk_cnt("take at enable", 0, l);
    rd_chk(OFS_CTRL, 32'h1);
    run_op(OP_NONE, 13'h0204, 1'b0);
    chk_val("vector after enable", vec(0, 3), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    wr(OFS_CTRL, 32'h3);
    pulse(8'h01);
    run_op(OP_NONE, 13'h0205, 1'b0);
    chk_val("moved vector", vec(BOOT, 0), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    @(posedge pclk);
    boot_section_lock_b <= 1'b1;
    pulse(8'h01);
    run_op(OP_NONE, 13'h0040, 1'b0);
    chk_cnt("boot lock take", 0, l);
    run_op(OP_NONE, 13'h1c20, 1'b0);
    chk_val("boot lock vector", vec(BOOT, 0), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    @(posedge pclk);
    boot_section_lock_b <= 1'b0;
    app_section_lock_a <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    pulse(8'h80);
    run_op(OP_NONE, 13'h1c10, 1'b0);
    chk_cnt("app lock take", 0, l);
    run_op(OP_NONE, 13'h0040, 1'b0);
    chk_val("app lock vector", vec(0, 7), a);
    run_op(OP_RET, 13'h0000, 1'b0);
    @(posedge pclk);
    app_section_lock_a <= 1'b0;
    wr(OFS_LEVEL, 32'h02);
    wr(OFS_CTRL, 32'h0);
    pulse(8'h02);
    rd_chk(OFS_FLAG, 32'h0);
    wr(OFS_CTRL, 32'h1);
    run_op(OP_NONE, 13'h0206, 1'b0);
    chk_cnt("vanished level", 0, l);
    @(posedge pclk);
    irq_cond <= 8'h02;
    run_op(OP_NONE, 13'h0207, 1'b0);
    chk_val("level vector", vec(0, 1), a);
    @(posedge pclk);
    irq_cond <= 8'h00;
    run_op(OP_RET, 13'h0000, 1'b0);
    pulse(8'h10);
    l = n_loads;
    repeat (4) @(posedge pclk);
    #1;
    chk_cnt("take mid instruction", l, n_loads);
    run_op(OP_NONE, 13'h0300, 1'b1);
    chk_cnt("sleep entry cycles", 9, c);
    run_op(OP_RET, 13'h0000, 1'b0);
    @(posedge pclk);
    boot_reset_fuse <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk_val("boot reset vector", BOOT, 32'(reset_vector));
    rd_chk(OFS_STATUS, 32'h0001_0001);
    tally_and_finish();
  end
endmodule : interrupt_vectoring_control_tb_top
